// File: core/dtic_debounce.v
// Per-line debouncing filter: output follows input after it is stable for a count.
module dtic_debounce #(
  parameter CW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire enable,
  input wire [CW-1:0] hold_cycles,
  input wire din,
  output reg dout
);
  reg [CW-1:0] count;

  // A change must persist for hold_cycles clocks before it is passed on.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= {CW{1'b0}};
      dout <= 1'b0;
    end else if (!enable || din == dout) begin
      count <= {CW{1'b0}};
      if (!enable) dout <= din;
    end else if (count + 1'b1 >= hold_cycles) begin
      count <= {CW{1'b0}};
      dout <= din;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// File: core/dtic_map.vh
// Constants shared by the digital trigger input conditioner files.
`ifndef DTIC_MAP_VH
`define DTIC_MAP_VH
`define DTIC_NUM_SRC 13
`define DTIC_SRC_W 4
`define DTIC_SRC_UFI0 4'h0
`define DTIC_SRC_UFI1 4'h1
`define DTIC_SRC_DSTAR_A 4'h2
`define DTIC_SRC_DSTAR_B 4'h3
`define DTIC_SRC_TRIG0 4'h4
`define DTIC_SRC_STAR 4'hC
`define DTIC_DET_RISE 2'h0
`define DTIC_DET_FALL 2'h1
`define DTIC_DET_LEVEL 2'h2
`define DTIC_MODE_START 2'h0
`define DTIC_MODE_REF 2'h1
`define DTIC_MODE_PAUSE 2'h2
`define DTIC_FSEL_90NS 2'h0
`define DTIC_FSEL_5120NS 2'h1
`define DTIC_FSEL_2560NS 2'h2
`define DTIC_FSEL_CUSTOM 2'h3
`define DTIC_CLK_MHZ 100
`define DTIC_T_90NS 90
`define DTIC_T_5120NS 5120
`define DTIC_T_2560NS 2560
`define DTIC_CYC_90NS ((`DTIC_T_90NS * `DTIC_CLK_MHZ + 999) / 1000)
`define DTIC_CYC_5120NS ((`DTIC_T_5120NS * `DTIC_CLK_MHZ + 999) / 1000)
`define DTIC_CYC_2560NS ((`DTIC_T_2560NS * `DTIC_CLK_MHZ + 999) / 1000)
`define DTIC_CNT_W 16
`define DTIC_DEB_CYC 16'h0008
`endif

// File: core/dtic_top.v
// Digital trigger input conditioner: source select, detect, qualify, acquisition control.
`include "dtic_map.vh"
module dtic_top #(
  parameter CW = 16
) (
  input wire clk_sys,
  input wire resetn,
  input wire [1:0] user_function_input,
  input wire dstar_a,
  input wire dstar_b,
  input wire [7:0] bus_trig,
  input wire star_trig,
  input wire sync_clk,
  input wire [`DTIC_NUM_SRC-1:0] deb_enable,
  input wire [CW-1:0] deb_cycles,
  input wire [`DTIC_SRC_W-1:0] src_sel,
  input wire [1:0] det_sel,
  input wire [1:0] mode_sel,
  input wire filt_enable,
  input wire [1:0] filt_sel,
  input wire [CW-1:0] filt_custom,
  input wire skew_enable,
  input wire arm,
  input wire sample_tick,
  input wire [CW-1:0] pre_count,
  input wire [CW-1:0] post_count,
  input wire ref_clk_use_bus10,
  input wire over_power,
  input wire acc_present_in,
  output reg acq_run,
  output reg acq_done,
  output reg trig_seen,
  output reg cfg_error,
  output reg acc_power_en,
  output reg acc_fault,
  output reg acc_present,
  output reg star_trig_oe,
  output reg ref_clk_bus10_sel
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PRE = 2'h1;
  localparam ST_POST = 2'h2;
  localparam ST_DONE = 2'h3;
  // Fixed intervals in cycles, held 32 bits wide and cut to the counter width where used.
  localparam [31:0] LIM_90 = `DTIC_CYC_90NS;
  localparam [31:0] LIM_5120 = `DTIC_CYC_5120NS;
  localparam [31:0] LIM_2560 = `DTIC_CYC_2560NS;

  reg rst_s1, rst_s2;
  wire rst_n = rst_s2;
  reg [`DTIC_NUM_SRC-1:0] pin_s1, pin_s2;
  reg sync_s1, sync_s2, sync_d;
  reg acc_s1, acc_s2;
  wire [`DTIC_NUM_SRC-1:0] raw_in = {star_trig, bus_trig, dstar_b, dstar_a, user_function_input};
  wire [`DTIC_NUM_SRC-1:0] deb_out;
  reg sel_d, sel_q, cond;
  reg [CW-1:0] filt_cnt, filt_lim;
  reg qual, qual_d, held, skew_pend;
  reg [1:0] state;
  reg [CW-1:0] samp_cnt;
  wire trig_evt = held & ~qual_d;
  wire cfg_bad = (mode_sel == `DTIC_MODE_PAUSE) && (det_sel != `DTIC_DET_LEVEL);

  // Reset release is synchronised so all flops on rst_n leave reset on the same edge.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Pins are asynchronous to the timebase, so each passes two flops first.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= {`DTIC_NUM_SRC{1'b0}};
      pin_s2 <= {`DTIC_NUM_SRC{1'b0}};
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_d <= 1'b0;
      acc_s1 <= 1'b0;
      acc_s2 <= 1'b0;
    end else begin
      pin_s1 <= raw_in;
      pin_s2 <= pin_s1;
      sync_s1 <= sync_clk;
      sync_s2 <= sync_s1;
      sync_d <= sync_s2;
      acc_s1 <= acc_present_in;
      acc_s2 <= acc_s1;
    end
  end

  // One debouncer per line; each has its own enable bit.
  genvar gi;
  generate
    for (gi = 0; gi < `DTIC_NUM_SRC; gi = gi + 1) begin : g_deb
      dtic_debounce #(.CW(CW)) u_deb (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(deb_enable[gi]),
        .hold_cycles(deb_cycles),
        .din(pin_s2[gi]),
        .dout(deb_out[gi])
      );
    end
  endgenerate

  // Source multiplexer; codes above the star line select nothing.
  always @* begin
    sel_d = 1'b0;
    if (src_sel < `DTIC_NUM_SRC) sel_d = deb_out[src_sel];
  end

  // Detector: edges give a one-cycle condition, level passes straight.
  always @* begin
    case (det_sel)
      `DTIC_DET_RISE: cond = sel_d & ~sel_q;
      `DTIC_DET_FALL: cond = ~sel_d & sel_q;
      `DTIC_DET_LEVEL: cond = sel_d;
      default: cond = 1'b0;
    endcase
  end

  // Qualification interval select; fixed choices round up to whole cycles.
  always @* begin
    case (filt_sel)
      `DTIC_FSEL_90NS: filt_lim = LIM_90[CW-1:0];
      `DTIC_FSEL_5120NS: filt_lim = LIM_5120[CW-1:0];
      `DTIC_FSEL_2560NS: filt_lim = LIM_2560[CW-1:0];
      default: filt_lim = (filt_custom == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : filt_custom;
    endcase
  end

  // Filter counts consecutive true cycles; an edge condition lasts one cycle,
  // so a filtered edge trigger only qualifies with a one-cycle interval.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      filt_cnt <= {CW{1'b0}};
      qual <= 1'b0;
    end else begin
      sel_q <= sel_d;
      if (!filt_enable) begin
        filt_cnt <= {CW{1'b0}};
        qual <= cond;
      end else if (!cond) begin
        filt_cnt <= {CW{1'b0}};
        qual <= 1'b0;
      end else if (filt_cnt + 1'b1 >= filt_lim) begin
        qual <= 1'b1;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  // Skew correction holds the trigger until the next sync clock rising edge.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
      qual_d <= 1'b0;
      skew_pend <= 1'b0;
    end else begin
      qual_d <= held;
      if (!skew_enable) begin
        held <= qual;
        skew_pend <= 1'b0;
      end else begin
        if (qual) skew_pend <= 1'b1;
        else if (sync_s2 & ~sync_d) skew_pend <= 1'b0;
        if (sync_s2 & ~sync_d) held <= qual | skew_pend;
      end
    end
  end

  // Acquisition control for start, reference and pause modes.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      samp_cnt <= {CW{1'b0}};
      acq_run <= 1'b0;
      acq_done <= 1'b0;
      trig_seen <= 1'b0;
      cfg_error <= 1'b0;
    end else begin
      cfg_error <= cfg_bad;
      if (!arm) begin
        state <= ST_IDLE;
        acq_run <= 1'b0;
        acq_done <= 1'b0;
        trig_seen <= 1'b0;
        samp_cnt <= {CW{1'b0}};
      end else begin
        case (mode_sel)
          `DTIC_MODE_START: begin
            if (trig_evt) begin
              acq_run <= 1'b1;
              trig_seen <= 1'b1;
            end
          end
          `DTIC_MODE_REF: begin
            case (state)
              ST_IDLE: begin
                acq_run <= 1'b1;
                samp_cnt <= {CW{1'b0}};
                state <= ST_PRE;
              end
              ST_PRE: begin
                if (sample_tick && samp_cnt < pre_count) samp_cnt <= samp_cnt + 1'b1;
                if (trig_evt && samp_cnt >= pre_count) begin
                  trig_seen <= 1'b1;
                  samp_cnt <= {CW{1'b0}};
                  state <= ST_POST;
                end
              end
              ST_POST: begin
                if (sample_tick) samp_cnt <= samp_cnt + 1'b1;
                if (sample_tick && samp_cnt + 1'b1 >= post_count) begin
                  acq_run <= 1'b0;
                  acq_done <= 1'b1;
                  state <= ST_DONE;
                end
              end
              default: state <= ST_DONE;
            endcase
          end
          `DTIC_MODE_PAUSE: begin
            acq_run <= ~cfg_bad & ~held;
            trig_seen <= held;
          end
          default: acq_run <= 1'b0;
        endcase
      end
    end
  end

  // Accessory power latches off on a fault; only device reset restores it.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_power_en <= 1'b0;
      acc_fault <= 1'b0;
      acc_present <= 1'b0;
      star_trig_oe <= 1'b0;
      ref_clk_bus10_sel <= 1'b0;
    end else begin
      if (over_power) acc_fault <= 1'b1;
      acc_power_en <= ~acc_fault & ~over_power;
      acc_present <= acc_s2;
      star_trig_oe <= 1'b0;
      ref_clk_bus10_sel <= 1'b0;
    end
  end
endmodule

// File: tb/dtic_bp_model.sv
// Backplane model: bused, star and sync lines seen by the module.
module dtic_bp_model (
  input wire [10:0] req,
  output logic dstar_a,
  output logic dstar_b,
  output logic [7:0] bus_trig,
  output logic star_trig,
  output logic sync_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines carry what the bench asks for; the star line comes from us only.
  assign {star_trig, bus_trig, dstar_b, dstar_a} = req;
  // Sync clock at 10 MHz with a 10 percent high time.
  initial begin
    forever begin
      sync_clk = 1'b1;
      #10;
      sync_clk = 1'b0;
      #90;
    end
  end
endmodule

// File: tb/dtic_chk.sv
// Port checker for the trigger conditioner.
module dtic_chk (
  input wire clk_sys,
  input wire resetn,
  input wire arm,
  input wire [1:0] det_sel,
  input wire [1:0] mode_sel,
  input wire over_power,
  input wire acc_present_in,
  input wire acq_run,
  input wire cfg_error,
  input wire acc_power_en,
  input wire acc_fault,
  input wire acc_present,
  input wire star_trig_oe,
  input wire ref_clk_bus10_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Steps of the fault latch, a bad pause set-up, a disarmed spell and an armed start run.
  sequence s_latch;
    ##[1:3] acc_fault;
  endsequence
  sequence s_bad_pause;
    (mode_sel == 2'h2 && det_sel != 2'h2)[*3];
  endsequence
  sequence s_idle;
    !arm[*3];
  endsequence
  sequence s_start_hold;
    (mode_sel == 2'h0 && arm && acq_run) ##1 (arm && mode_sel == 2'h0);
  endsequence
  chk_star_recv_only: assert property (!star_trig_oe)
    else $error("star line driven");
  chk_bus10_refused: assert property (!ref_clk_bus10_sel)
    else $error("bus clock chosen");
  chk_fault_latch: assert property (over_power |-> s_latch)
    else $error("fault not latched");
  chk_fault_sticky: assert property (acc_fault |=> acc_fault)
    else $error("fault flag dropped");
  chk_fault_power: assert property (acc_fault |=> !acc_power_en)
    else $error("power on after fault");
  chk_pause_level: assert property (s_bad_pause |-> cfg_error && !acq_run)
    else $error("edge pause accepted");
  chk_idle_no_run: assert property (s_idle |-> !acq_run)
    else $error("run while disarmed");
  chk_start_holds: assert property (s_start_hold |-> acq_run)
    else $error("start run dropped");
  chk_present_seen: assert property ($past(resetn, 3) ##0 acc_present_in[*4] |-> acc_present)
    else $error("accessory not seen");
  chk_absent_seen: assert property (!acc_present_in[*4] |-> !acc_present)
    else $error("accessory ghost");
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the trigger conditioner.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] s; logic [1:0] d; logic i; logic f; logic e;} dtic_row_t;
  logic clk_sys = 1'b0, resetn = 1'b0, fen = 1'b0, skew = 1'b0, arm = 1'b0;
  logic tick = 1'b0, ovp = 1'b0, pres = 1'b0, b10 = 1'b1, sync_d = 1'b0;
  logic [12:0] lines = 13'h0000, deb_en = 13'h0000;
  logic [3:0] src = 4'h0;
  logic [1:0] det = 2'h2, mode = 2'h0, fsel = 2'h0;
  logic [15:0] deb_cyc = 16'h0002, fcust = 16'h0003, pre = 16'h0003, post = 16'h0002;
  wire dstar_a, dstar_b, star_trig, sync_clk, run, done, seen, cerr, pwr, flt, present;
  wire soe, b10sel;
  wire [7:0] bus_trig;
  int failures = 0, num_checks = 0, since = 0;
  int lens [4] = '{9, 512, 256, 3};
  dtic_row_t rows [8] = '{'{4'h0, 2'h0, 1'b0, 1'b1, 1'b1}, '{4'h1, 2'h1, 1'b1, 1'b0, 1'b1},
    '{4'h2, 2'h0, 1'b1, 1'b0, 1'b0}, '{4'h3, 2'h1, 1'b0, 1'b1, 1'b0},
    '{4'h4, 2'h2, 1'b0, 1'b0, 1'b0}, '{4'hB, 2'h3, 1'b0, 1'b1, 1'b0},
    '{4'hC, 2'h2, 1'b0, 1'b1, 1'b1}, '{4'hD, 2'h2, 1'b0, 1'b1, 1'b0}};
  // The 100 MHz reference clock that the chassis hands to every slot.
  always #5 clk_sys = ~clk_sys;
  // Cycles since the last sync rise, to place triggers against it.
  always @(posedge clk_sys) begin
    sync_d <= sync_clk;
    since <= (sync_clk && !sync_d) ? 0 : since + 1;
  end
  dtic_bp_model i_bp (.req(lines[12:2]), .dstar_a(dstar_a), .dstar_b(dstar_b),
    .bus_trig(bus_trig), .star_trig(star_trig), .sync_clk(sync_clk));
  dtic_top #(.CW(16)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .user_function_input(lines[1:0]), .dstar_a(dstar_a), .dstar_b(dstar_b),
    .bus_trig(bus_trig), .star_trig(star_trig), .sync_clk(sync_clk), .deb_enable(deb_en),
    .deb_cycles(deb_cyc), .src_sel(src), .det_sel(det), .mode_sel(mode),
    .filt_enable(fen), .filt_sel(fsel), .filt_custom(fcust), .skew_enable(skew),
    .arm(arm), .sample_tick(tick), .pre_count(pre), .post_count(post),
    .ref_clk_use_bus10(b10), .over_power(ovp), .acc_present_in(pres), .acq_run(run),
    .acq_done(done), .trig_seen(seen), .cfg_error(cerr), .acc_power_en(pwr),
    .acc_fault(flt), .acc_present(present), .star_trig_oe(soe), .ref_clk_bus10_sel(b10sel));
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One row: set the pin, arm, move the pin, then look at the run flags.
  task automatic run_row(input dtic_row_t r);
    @(posedge clk_sys);
    arm <= 1'b0;
    mode <= 2'h0;
    src <= r.s;
    det <= r.d;
    lines <= 13'(r.i) << r.s;
    cyc(8);
    arm <= 1'b1;
    cyc(8);
    lines <= 13'(r.f) << r.s;
    cyc(12);
    chk("acq_run", r.e, run);
    chk("trig_seen", r.e, seen);
  endtask
  // A pulse one cycle short of the interval must not pass; a held level must.
  task automatic filt_case(input logic fe, input logic [1:0] fs, input int n);
    @(posedge clk_sys);
    arm <= 1'b0;
    mode <= 2'h0;
    src <= 4'h0;
    det <= 2'h2;
    fen <= fe;
    fsel <= fs;
    lines <= 13'h0000;
    cyc(2);
    arm <= 1'b1;
    cyc(2);
    lines <= 13'h0001;
    cyc(n - 1);
    lines <= 13'h0000;
    cyc(12);
    chk("short pulse", 1'b0, run);
    lines <= 13'h0001;
    cyc(n + 12);
    chk("held level", 1'b1, run);
    arm <= 1'b0;
  endtask
  task automatic tick1;
    @(posedge clk_sys);
    tick <= 1'b1;
    @(posedge clk_sys);
    tick <= 1'b0;
    cyc(3);
  endtask
  // The watchdog is far beyond the few thousand cycles the tests need.
  initial begin
    cyc(20000);
    failures++;
    report_and_stop;
  end
  initial begin
    cyc(4);
    chk("power in reset", 1'b0, pwr);
    resetn <= 1'b1;
    cyc(6);
    chk("power up", 1'b1, pwr);
    chk("bus clock sel", 1'b0, b10sel);
    $display("test reset done");
    foreach (rows[k]) run_row(rows[k]);
    for (int s = 0; s < 13; s++) run_row({4'(s), 2'h2, 1'b0, 1'b1, 1'b1});
    $display("test rows done");
    for (int f = 0; f < 4; f++) filt_case(1'b1, 2'(f), lens[f]);
    fen <= 1'b0;
    deb_en <= 13'h1FFF;
    filt_case(1'b0, 2'h0, 2);
    deb_en <= 13'h0000;
    // The line drops while disarmed, so the next rise is a real trigger in the pre phase.
    lines <= 13'h0000;
    $display("test filters done");
    cyc(4);
    mode <= 2'h1;
    arm <= 1'b1;
    lines <= 13'h0001;
    cyc(10);
    lines <= 13'h0000;
    repeat (5) tick1;
    chk("early trigger", 1'b0, done);
    chk("early seen", 1'b0, seen);
    lines <= 13'h0001;
    cyc(10);
    tick1;
    chk("one post", 1'b0, done);
    tick1;
    cyc(6);
    chk("record done", 1'b1, done);
    chk("ref stopped", 1'b0, run);
    chk("ref seen", 1'b1, seen);
    $display("test reference done");
    arm <= 1'b0;
    lines <= 13'h0000;
    mode <= 2'h2;
    cyc(2);
    arm <= 1'b1;
    cyc(12);
    chk("pause idle", 1'b1, run);
    lines <= 13'h0001;
    cyc(12);
    chk("pause hold", 1'b0, run);
    lines <= 13'h0000;
    cyc(12);
    chk("pause resume", 1'b1, run);
    det <= 2'h0;
    cyc(8);
    chk("pause edge", 1'b1, cerr);
    chk("pause edge run", 1'b0, run);
    $display("test pause done");
    arm <= 1'b0;
    det <= 2'h2;
    mode <= 2'h0;
    skew <= 1'b1;
    cyc(2);
    arm <= 1'b1;
    while (since != 1) @(posedge clk_sys);
    lines <= 13'h0001;
    cyc(8);
    chk("skew wait", 1'b0, run);
    cyc(16);
    chk("skew run", 1'b1, run);
    mode <= 2'h3;
    cyc(4);
    chk("idle mode", 1'b0, run);
    $display("test skew done");
    pres <= 1'b1;
    ovp <= 1'b1;
    cyc(1);
    ovp <= 1'b0;
    cyc(6);
    chk("present", 1'b1, present);
    chk("fault", 1'b1, flt);
    chk("power off", 1'b0, pwr);
    chk("star drive", 1'b0, soe);
    resetn <= 1'b0;
    cyc(4);
    resetn <= 1'b1;
    cyc(6);
    chk("power back", 1'b1, pwr);
    chk("fault cleared", 1'b0, flt);
    $display("test power done");
    report_and_stop;
  end
endmodule
bind dtic_top dtic_chk i_chk (.clk_sys(clk_sys), .resetn(resetn), .arm(arm),
  .det_sel(det_sel), .mode_sel(mode_sel), .over_power(over_power),
  .acc_present_in(acc_present_in), .acq_run(acq_run), .cfg_error(cfg_error),
  .acc_power_en(acc_power_en), .acc_fault(acc_fault), .acc_present(acc_present),
  .star_trig_oe(star_trig_oe), .ref_clk_bus10_sel(ref_clk_bus10_sel));
